// >>> bhld_pkg.sv
// shared constants and types for the bus hold arbiter
package bhld_pkg;

    // source indices, highest priority first
    localparam int SRC_OPERAND  = 0;
    localparam int SRC_REFRESH  = 1;
    localparam int SRC_HOLD     = 2;
    localparam int SRC_VEC_STEP = 3;
    localparam int SRC_VEC_NMI  = 4;
    localparam int SRC_VEC_EXC  = 5;
    localparam int SRC_VEC_HW   = 6;
    localparam int SRC_VEC_CPE  = 7;
    localparam int SRC_EXEC     = 8;
    localparam int SRC_PREFETCH = 9;
    localparam int NUM_SRC      = 10;

    localparam int SYNC_STAGES     = 2;
    localparam int BOOT_CYCLES     = 2;
    localparam int POST_HOLD_IDLES = 2;

    localparam logic [NUM_SRC-1:0] GRANT_RESET = 10'h000;
    localparam logic [1:0]         BOOT_RESET  = 2'h0;

    typedef enum logic [3:0] {
        BHLD_BOOT,
        BHLD_IDLE,
        BHLD_T1,
        BHLD_T2,
        BHLD_T3,
        BHLD_T4,
        BHLD_HOLD,
        BHLD_REL_FLOAT,
        BHLD_REL_LAST,
        BHLD_PARK
    } bhld_state_t;

    // one bus cycle request from the core, attributes apply to the source granted next
    typedef struct packed {
        logic [NUM_SRC-1:0] req;
        logic               word;
        logic               odd;
        logic               inta;
    } bhld_req_t;

    // output enables of the released bus lines, high while driven
    typedef struct packed {
        logic mux_addr_data;
        logic data_enable_n;
        logic upper_addr;
        logic strobes;
        logic byte_high_en_n;
        logic data_direction;
        logic bus_status;
    } bhld_drive_t;

    // lines that stay driven through hold
    typedef struct packed {
        logic addr_latch_en;
        logic upper_mem_select;
        logic lower_mem_select;
        logic general_selects;
        logic peripherals;
    } bhld_keep_t;

endpackage

// >>> bhld_sync.sv
// two-stage synchroniser for asynchronous pins
`timescale 1ns/100ps
module bhld_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            meta     <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule // bhld_sync

// >>> bhld_prio.sv
// fixed priority picker with lock elevation
`timescale 1ns/100ps
module bhld_prio #(
    parameter int N = bhld_pkg::NUM_SRC
) (
    input  wire logic [N-1:0] req,
    input  wire logic         lock_active,
    output logic      [N-1:0] grant,
    output logic              any
);
    logic [N-1:0] eff;

    always_comb
    begin
        eff   = req;
        grant = '0;
        // a locked instruction outranks everything, refresh included
        if (lock_active && req[bhld_pkg::SRC_EXEC])
        begin
            eff = '0;
            eff[bhld_pkg::SRC_EXEC] = 1'b1;
        end
        for (int i = N - 1; i >= 0; i--)
        begin
            if (eff[i])
            begin
                grant    = '0;
                grant[i] = 1'b1;
            end
        end
        any = |eff;
    end
endmodule // bhld_prio

// >>> bhld_arbiter.sv
// bus unit sequencer with hold/acknowledge hand-over and cycle arbitration
`timescale 1ns/100ps
module bhld_arbiter #(
    parameter bit BUS_8BIT = 1'b0
) (
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    input  wire logic                          hold_req,
    input  wire logic                          error_pin,
    input  wire bhld_pkg::bhld_req_t           core_req,
    input  wire logic                          lock_active,
    input  wire logic                          numerics_active,
    input  wire logic                          error_taken,
    output logic                               hold_ack,
    output bhld_pkg::bhld_drive_t              drive_oe,
    output bhld_pkg::bhld_keep_t               keep_oe,
    output logic                               status_drive,
    output logic [bhld_pkg::NUM_SRC-1:0]       grant,
    output bhld_pkg::bhld_state_t              bus_state,
    output logic                               cycle_start,
    output logic                               coproc_error
);

    bhld_pkg::bhld_state_t           state;
    bhld_pkg::bhld_state_t           next_state;
    logic                            hold_sync;
    logic                            error_sync;
    logic [1:0]                      boot_count;
    logic                            pair_pending;
    logic                            next_pair_pending;
    logic                            inta_second;
    logic                            next_inta_second;
    logic [bhld_pkg::NUM_SRC-1:0]    cur_src;
    logic [bhld_pkg::NUM_SRC-1:0]    next_src;
    logic [bhld_pkg::NUM_SRC-1:0]    arb_req;
    logic [bhld_pkg::NUM_SRC-1:0]    arb_grant;
    logic                            arb_any;
    logic                            hold_allowed;
    logic                            start_cycle;
    logic                            core_pending;

    function automatic logic floated(input bhld_pkg::bhld_state_t s);
        floated = (s == bhld_pkg::BHLD_HOLD) || (s == bhld_pkg::BHLD_REL_FLOAT) ||
                  (s == bhld_pkg::BHLD_PARK);
    endfunction

    // asynchronous pins pass two flops before use
    bhld_sync #(
        .WIDTH (2)
    ) u_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in ({hold_req, error_pin}),
        .sync_out ({hold_sync, error_sync})
    );

    // hold may not split a locked transfer or an inseparable pair
    always_comb
    begin
        hold_allowed = hold_sync && !lock_active && !pair_pending && !inta_second;
        arb_req      = core_req.req;
        arb_req[bhld_pkg::SRC_HOLD] = hold_allowed;
        core_pending = |core_req.req;
    end

    bhld_prio #(
        .N (bhld_pkg::NUM_SRC)
    ) u_prio (
        .req         (arb_req),
        .lock_active (lock_active),
        .grant       (arb_grant),
        .any         (arb_any)
    );

    // next state of the bus unit
    always_comb
    begin
        next_state        = state;
        next_src          = cur_src;
        next_pair_pending = pair_pending;
        next_inta_second  = inta_second;
        start_cycle       = 1'b0;
        case (state)
            bhld_pkg::BHLD_BOOT:
            begin
                // let the hold synchroniser settle before the first fetch
                if (boot_count == bhld_pkg::BOOT_CYCLES[1:0] - 2'h1)
                begin
                    next_state = bhld_pkg::BHLD_IDLE;
                end
            end
            bhld_pkg::BHLD_IDLE, bhld_pkg::BHLD_T4:
            begin
                // decisions happen only at a cycle boundary or while idle
                if (pair_pending || inta_second)
                begin
                    next_state        = bhld_pkg::BHLD_T1;
                    start_cycle       = 1'b1;
                    next_pair_pending = 1'b0;
                    next_inta_second  = 1'b0;
                end
                else if (arb_grant[bhld_pkg::SRC_HOLD])
                begin
                    next_state = bhld_pkg::BHLD_HOLD;
                end
                else if (arb_any)
                begin
                    next_state  = bhld_pkg::BHLD_T1;
                    next_src    = arb_grant;
                    start_cycle = 1'b1;
                    // only core sources carry the pairing attributes
                    next_pair_pending = core_req.word && (core_req.odd || BUS_8BIT);
                    next_inta_second  = core_req.inta && arb_grant[bhld_pkg::SRC_VEC_HW];
                end
                else
                begin
                    next_state = bhld_pkg::BHLD_IDLE;
                end
            end
            bhld_pkg::BHLD_T1:
            begin
                next_state = bhld_pkg::BHLD_T2;
            end
            bhld_pkg::BHLD_T2:
            begin
                next_state = bhld_pkg::BHLD_T3;
            end
            bhld_pkg::BHLD_T3:
            begin
                next_state = bhld_pkg::BHLD_T4;
            end
            bhld_pkg::BHLD_HOLD:
            begin
                if (!hold_sync || core_req.req[bhld_pkg::SRC_REFRESH])
                begin
                    next_state = bhld_pkg::BHLD_REL_FLOAT;
                end
            end
            bhld_pkg::BHLD_REL_FLOAT:
            begin
                // first of the two idles after hold
                if (core_pending)
                begin
                    next_state = bhld_pkg::BHLD_REL_LAST;
                end
                else
                begin
                    next_state = bhld_pkg::BHLD_PARK;
                end
            end
            bhld_pkg::BHLD_PARK:
            begin
                if (hold_allowed && !core_req.req[bhld_pkg::SRC_REFRESH])
                begin
                    next_state = bhld_pkg::BHLD_HOLD;
                end
                else if (core_pending)
                begin
                    next_state = bhld_pkg::BHLD_REL_LAST;
                end
            end
            bhld_pkg::BHLD_REL_LAST:
            begin
                // arbitration already known; status goes out in this idle
                next_state  = bhld_pkg::BHLD_T1;
                start_cycle = 1'b1;
                next_src    = arb_grant & ~(10'h004);
                next_pair_pending = core_req.word && (core_req.odd || BUS_8BIT);
                next_inta_second  = core_req.inta && arb_grant[bhld_pkg::SRC_VEC_HW];
                if (!arb_any || (arb_grant == 10'h004))
                begin
                    // demand vanished or hold won; go back to a floated wait
                    next_state        = bhld_pkg::BHLD_PARK;
                    start_cycle       = 1'b0;
                    next_src          = cur_src;
                    next_pair_pending = pair_pending;
                    next_inta_second  = inta_second;
                end
            end
            default:
            begin
                next_state = bhld_pkg::BHLD_BOOT;
            end
        endcase
    end

    // state register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state <= bhld_pkg::BHLD_BOOT;
        end
        else
        begin
            state <= next_state;
        end
    end

    // boot delay counter
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            boot_count <= bhld_pkg::BOOT_RESET;
        end
        else if (state == bhld_pkg::BHLD_BOOT)
        begin
            boot_count <= boot_count + 2'h1;
        end
    end

    // cycle bookkeeping
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            cur_src      <= bhld_pkg::GRANT_RESET;
            pair_pending <= 1'b0;
            inta_second  <= 1'b0;
        end
        else
        begin
            cur_src      <= next_src;
            pair_pending <= next_pair_pending;
            inta_second  <= next_inta_second;
        end
    end

    // hold acknowledge and line enables, all from flops
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            hold_ack     <= 1'b0;
            drive_oe     <= '1;
            status_drive <= 1'b0;
        end
        else
        begin
            hold_ack     <= (next_state == bhld_pkg::BHLD_HOLD);
            drive_oe     <= floated(next_state) ? '0 : '1;
            status_drive <= (next_state == bhld_pkg::BHLD_REL_LAST) ||
                            (next_state == bhld_pkg::BHLD_T1);
        end
    end

    // these never float, hold or not
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            keep_oe <= '1;
        end
        else
        begin
            keep_oe <= '1;
        end
    end

    // visible cycle information
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            grant       <= bhld_pkg::GRANT_RESET;
            bus_state   <= bhld_pkg::BHLD_BOOT;
            cycle_start <= 1'b0;
        end
        else
        begin
            grant       <= next_src;
            bus_state   <= next_state;
            cycle_start <= start_cycle;
        end
    end

    // coprocessor error latch; a new sample wins over the clear
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            coproc_error <= 1'b0;
        end
        else if (error_sync && numerics_active)
        begin
            coproc_error <= 1'b1;
        end
        else if (error_taken)
        begin
            coproc_error <= 1'b0;
        end
    end

endmodule // bhld_arbiter

// >>> bhld_master_model.sv
// external bus master model that asks for the bus with a hold request
`timescale 1ns/100ps
module bhld_master_model (
    input  wire logic       sys_clk,
    input  wire logic       want,
    input  wire logic [7:0] use_len,
    input  wire logic       hold_ack,
    output logic            hold_req
);
    logic       want_q;
    logic [7:0] used;
    logic       done;
    initial
    begin
        hold_req = 1'b0;
        want_q   = 1'b0;
        used     = 8'h00;
        done     = 1'b0;
    end
    // want is resampled first so the pin never moves in the bench's own time step
    always @(posedge sys_clk)
        want_q <= want;
    // pin moves off the falling edge: it is asynchronous to the unit
    always @(negedge sys_clk)
    begin
        if (!want_q)
        begin
            hold_req <= 1'b0;
            used     <= 8'h00;
            done     <= 1'b0;
        end
        else if (!done)
        begin
            hold_req <= 1'b1;
            if (hold_ack)
                used <= used + 8'h01;
            if (used == use_len)
            begin
                hold_req <= 1'b0;
                done     <= 1'b1;
            end
        end
    end
endmodule // bhld_master_model

// >>> bhld_arbiter_checker.sv
// concurrent checks on the bus hold arbiter ports
`timescale 1ns/100ps
module bhld_arbiter_checker (
    input wire logic                    sys_clk,
    input wire logic                    rst,
    input wire logic                    hold_req,
    input wire logic                    error_pin,
    input wire bhld_pkg::bhld_req_t     core_req,
    input wire logic                    lock_active,
    input wire logic                    numerics_active,
    input wire logic                    error_taken,
    input wire logic                    hold_ack,
    input wire bhld_pkg::bhld_drive_t   drive_oe,
    input wire bhld_pkg::bhld_keep_t    keep_oe,
    input wire logic                    status_drive,
    input wire logic [9:0]              grant,
    input wire bhld_pkg::bhld_state_t   bus_state,
    input wire logic                    cycle_start,
    input wire logic                    coproc_error
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    float_hold_a:
        assert property (hold_ack |-> drive_oe == '0)
        else $error("bus lines driven in hold");
    keep_driven_a:
        assert property (keep_oe == '1)
        else $error("kept line floated");
    cycle_whole_a:
        assert property (cycle_start |-> bus_state == bhld_pkg::BHLD_T1 ##1
            bus_state == bhld_pkg::BHLD_T2 ##1 bus_state == bhld_pkg::BHLD_T3 ##1
            bus_state == bhld_pkg::BHLD_T4)
        else $error("bus cycle cut short");
    grant_at_end_a:
        assert property ($rose(hold_ack) |-> !($past(bus_state) inside {bhld_pkg::BHLD_T1,
            bhld_pkg::BHLD_T2, bhld_pkg::BHLD_T3, bhld_pkg::BHLD_REL_LAST}))
        else $error("hold granted mid cycle");
    idle_latency_a:
        assert property (($rose(hold_req) && bus_state == bhld_pkg::BHLD_IDLE) ##1
            (bus_state == bhld_pkg::BHLD_IDLE) ##1 (bus_state == bhld_pkg::BHLD_IDLE
            && !lock_active && core_req.req[1:0] == 2'h0) |-> !hold_ack ##1 hold_ack)
        else $error("idle hold latency wrong");
    lock_ignore_a:
        assert property (lock_active && !hold_ack |=> !hold_ack)
        else $error("hold granted under lock");
    ack_drop_a:
        assert property ($fell(hold_req) && hold_ack |-> ##[1:3] !hold_ack
            && bus_state == bhld_pkg::BHLD_REL_FLOAT && drive_oe == '0)
        else $error("hold ack not dropped");
    resume_a:
        assert property (bus_state == bhld_pkg::BHLD_REL_LAST |-> status_drive ##1
            bus_state == bhld_pkg::BHLD_T1 && cycle_start)
        else $error("resume sequence wrong");
    refresh_drop_a:
        assert property (core_req.req[bhld_pkg::SRC_REFRESH] && hold_ack |-> ##[1:2] !hold_ack)
        else $error("refresh left hold ack high");
    error_gate_a:
        assert property ($rose(coproc_error) |-> $past(numerics_active))
        else $error("error taken outside numerics");
endmodule // bhld_arbiter_checker
bind bhld_arbiter bhld_arbiter_checker chk_u (.sys_clk(sys_clk), .rst(rst),
    .hold_req(hold_req), .error_pin(error_pin), .core_req(core_req),
    .lock_active(lock_active), .numerics_active(numerics_active),
    .error_taken(error_taken), .hold_ack(hold_ack), .drive_oe(drive_oe),
    .keep_oe(keep_oe), .status_drive(status_drive), .grant(grant),
    .bus_state(bus_state), .cycle_start(cycle_start), .coproc_error(coproc_error));

// >>> bhld_arbiter_tb.sv
// self-checking bench for the bus hold arbiter
`timescale 1ns/100ps
module bhld_arbiter_tb;
    logic                  sys_clk, rst, hold_req, error_pin, want;
    logic                  lock_active, numerics_active, error_taken;
    logic [7:0]            ulen;
    bhld_pkg::bhld_req_t   creq;
    logic                  hold_ack, status_drive, cycle_start, coproc_error;
    bhld_pkg::bhld_drive_t drive_oe;
    bhld_pkg::bhld_keep_t  keep_oe;
    logic [9:0]            grant;
    bhld_pkg::bhld_state_t bus_state;
    int                    n_fail, checks, ncs, cyc;
    bhld_arbiter dut_u (.sys_clk(sys_clk), .rst(rst), .hold_req(hold_req),
        .error_pin(error_pin), .core_req(creq), .lock_active(lock_active),
        .numerics_active(numerics_active), .error_taken(error_taken),
        .hold_ack(hold_ack), .drive_oe(drive_oe), .keep_oe(keep_oe),
        .status_drive(status_drive), .grant(grant), .bus_state(bus_state),
        .cycle_start(cycle_start), .coproc_error(coproc_error));
    bhld_master_model mst_u (.sys_clk(sys_clk), .want(want), .use_len(ulen),
        .hold_ack(hold_ack), .hold_req(hold_req));
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic complete_run;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // whole run is a few hundred cycles; a hang lands here
    // counted off the falling edge so registered outputs have settled
    always @(negedge sys_clk)
    begin
        cyc++;
        if (cycle_start === 1'b1)
            ncs++;
        if (cyc > 3000)
        begin
            n_fail++;
            complete_run;
        end
    end
    task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wst(input bhld_pkg::bhld_state_t s);
        int n;
        n = 0;
        while (bus_state !== s && n < 60)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk("state", bus_state, s);
    endtask
    task automatic t_reset;
        wst(bhld_pkg::BHLD_HOLD);
        chk("cycles", 10'(ncs), 10'h000);
        chk("float", drive_oe, 10'h000);
        chk("keep", keep_oe, 10'h01f);
        wst(bhld_pkg::BHLD_REL_FLOAT);
        @(negedge sys_clk);
        chk("idle2", bus_state, bhld_pkg::BHLD_REL_LAST);
        chk("status", status_drive, 10'h001);
        @(negedge sys_clk);
        chk("resume", bus_state, bhld_pkg::BHLD_T1);
        want = 1'b0;
        creq = '0;
        wst(bhld_pkg::BHLD_IDLE);
        $display("done reset hold");
    endtask
    task automatic t_idle;
        int n;
        n = 0;
        ulen = 8'h03;
        want = 1'b1;
        do
        begin
            @(negedge sys_clk);
            n++;
        end while (hold_ack !== 1'b1 && n < 20);
        // one cycle to reach the pin, then sample, sync and grant
        chk("latency", 10'(n), 10'h004);
        wst(bhld_pkg::BHLD_PARK);
        chk("parked", drive_oe, 10'h000);
        want = 1'b0;
        repeat (4) @(negedge sys_clk);
        $display("done idle hold");
    endtask
    task automatic t_mid;
        bhld_pkg::bhld_state_t s;
        creq.req[bhld_pkg::SRC_EXEC] = 1'b1;
        wst(bhld_pkg::BHLD_T1);
        want = 1'b1;
        creq = '0;
        s = bus_state;
        while (hold_ack !== 1'b1 && cyc < 2900)
        begin
            s = bus_state;
            @(negedge sys_clk);
        end
        chk("prev", s, bhld_pkg::BHLD_T4);
        want = 1'b0;
        repeat (8) @(negedge sys_clk);
        $display("done mid cycle hold");
    endtask
    task automatic t_prio;
        int src[9] = '{0, 1, 3, 4, 5, 6, 7, 8, 9};
        foreach (src[k])
        begin
            // the source and every lower one except hold pending together
            creq.req = (10'h3ff << src[k]) & 10'h3fb;
            while (cycle_start !== 1'b1 && cyc < 2900)
                @(negedge sys_clk);
            chk("grant", grant, 10'h001 << src[k]);
            creq = '0;
            wst(bhld_pkg::BHLD_IDLE);
        end
        $display("done priority");
    endtask
    task automatic t_lock;
        ulen = 8'h03;
        lock_active = 1'b1;
        want = 1'b1;
        creq.req = 10'h102;
        while (cycle_start !== 1'b1 && cyc < 2900)
            @(negedge sys_clk);
        chk("locked", grant, 10'h100);
        repeat (12) @(negedge sys_clk);
        chk("no ack", hold_ack, 10'h000);
        lock_active = 1'b0;
        creq = '0;
        wst(bhld_pkg::BHLD_HOLD);
        creq.req = 10'h002;
        wst(bhld_pkg::BHLD_T1);
        chk("refresh", grant, 10'h002);
        creq = '0;
        want = 1'b0;
        repeat (12) @(negedge sys_clk);
        $display("done lock");
    endtask
    task automatic t_pair;
        for (int j = 0; j < 2; j++)
        begin
            // odd word access, then interrupt acknowledge pair
            creq.req  = j ? 10'h040 : 10'h100;
            creq.word = !j;
            creq.odd  = !j;
            creq.inta = j;
            ulen = 8'h02;
            wst(bhld_pkg::BHLD_T1);
            want = 1'b1;
            wst(bhld_pkg::BHLD_T4);
            @(negedge sys_clk);
            chk("pair", bus_state, bhld_pkg::BHLD_T1);
            chk("pair src", grant, creq.req);
            creq = '0;
            wst(bhld_pkg::BHLD_HOLD);
            want = 1'b0;
            repeat (8) @(negedge sys_clk);
        end
        $display("done pairs");
    endtask
    task automatic t_err;
        error_pin = 1'b1;
        repeat (6) @(negedge sys_clk);
        chk("no error", coproc_error, 10'h000);
        numerics_active = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk("error", coproc_error, 10'h001);
        numerics_active = 1'b0;
        error_pin = 1'b0;
        repeat (3) @(negedge sys_clk);
        error_taken = 1'b1;
        @(negedge sys_clk);
        error_taken = 1'b0;
        @(negedge sys_clk);
        chk("cleared", coproc_error, 10'h000);
        $display("done error");
    endtask
    initial
    begin
        n_fail = 0;
        checks = 0;
        ncs = 0;
        cyc = 0;
        rst = 1'b1;
        want = 1'b1;
        ulen = 8'h05;
        error_pin = 1'b0;
        lock_active = 1'b0;
        numerics_active = 1'b0;
        error_taken = 1'b0;
        creq = '0;
        creq.req[bhld_pkg::SRC_EXEC] = 1'b1;
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        t_reset;
        t_idle;
        t_mid;
        t_prio;
        t_lock;
        t_pair;
        t_err;
        complete_run;
    end
endmodule // bhld_arbiter_tb
